// ---- logic/mpw_top.sv ----
// Purpose: motion parameter store and input wait command unit
// Assumes: AXI4-Lite slave, one access of each kind at a time
// Notes: speeds in 0.0042 rev/sec steps
// Function
// - a query reply waits the programmed delay in ms, 0..32767, reset 0.
// - the change speed is kept up to 133.3333 rps with default 5 rps.
// - a speed-change feed runs at move speed, then at change speed.
// - the move speed is kept between 0.0042 and 80 rps.
// - jog moves ignore the move speed; the profile speed is 0 for them.
// - in analog velocity mode the commanded speed is clamped to the ceiling.
// - an input wait stalls the command buffer until its condition holds.
// - conditions are L low, H high, F falling and R rising.
// - during a wait pulse and heading jog if jog is on and mode is 21.
// - after jog is switched off the inputs no longer jog during a wait.
// - current flowing reads as low, no current or open reads as high.
// - for the analog input L is at or below the threshold and H above it.
// - every reply ends in a carriage return.
`timescale 1ns/1ps
`default_nettype none
module mpw_top
    import mpw_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins, 1 means no current
    input wire logic pulsePin,
    input wire logic headingPin,
    input wire logic gatePin,
    input wire logic [15:0] analogPin,
    // drive state
    input wire logic analogMode,
    // outputs
    output logic bufferStall,
    output logic jogInputsActive,
    output logic [15:0] profileSpeed,
    output logic [15:0] clampedSpeed,
    output logic replyGo
);
    logic [14:0] dly_q, dly_d;
    logic [15:0] chg_q, chg_d, mov_q, mov_d, ceil_q, ceil_d, prof_q, prof_d;
    logic [15:0] thr_q, thr_d, acmd_q, acmd_d, clamp_q, clamp_d;
    logic [4:0] mode_q, mode_d;
    logic stall_q, stall_d, jogAct_q, jogAct_d, go_q, go_d, jogOn_q, jogOn_d;
    logic [2:0] mctl_q, mctl_d;
    logic [31:0] reply_q, reply_d, wd_q, wd_d, rd_q, rd_d;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [2:0] s1_q, s2_q;
    logic [15:0] a1_q, a2_q;
    logic doWrite, waitStart, tmStart, tmBusy, tmFire;
    mpw_wait_if wif ();

    // two-stage sync of pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            a1_q <= 16'h0;
            a2_q <= 16'h0;
        end else begin
            s1_q <= {gatePin, headingPin, pulsePin};
            s2_q <= s1_q;
            a1_q <= analogPin;
            a2_q <= a1_q;
        end
    end

    // axi write channel
    assign doWrite = awHeld_q && wHeld_q && !bv_q;
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        if (s_axi_awvalid && !awHeld_q) begin
            awHeld_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_q) begin
            wHeld_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (doWrite) begin
            bv_d = 1'b1;
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            br_d = (awa_q > OFS_MOVE_CTRL || awa_q[1:0] != 2'h0
                    || awa_q == OFS_STATUS) ? RESP_SLVERR : RESP_OKAY;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
    end

    // settings and commands
    assign waitStart = doWrite && awa_q == OFS_INPUT_WAIT && !wif.pending;
    assign tmStart = doWrite && awa_q == OFS_REPLY_REQ && !tmBusy;
    always_comb begin
        dly_d = dly_q;
        chg_d = chg_q;
        mov_d = mov_q;
        ceil_d = ceil_q;
        thr_d = thr_q;
        acmd_d = acmd_q;
        jogOn_d = jogOn_q;
        mode_d = mode_q;
        mctl_d = mctl_q;
        reply_d = reply_q;
        if (doWrite && !wif.pending && s_axi_wstrb != 4'h0) begin
            case (awa_q)
                OFS_REPLY_DELAY: dly_d = (wd_q[15:0] > 16'(REPLY_DELAY_MAX))
                    ? REPLY_DELAY_MAX : wd_q[14:0];
                OFS_CHANGE_SPEED: chg_d = mpw_clamp(wd_q[15:0],
                    CEIL_SPEED_MAX);
                OFS_MOVE_SPEED: mov_d = mpw_clamp(wd_q[15:0],
                    MOVE_SPEED_MAX);
                OFS_SPEED_CEIL: ceil_d = mpw_clamp(wd_q[15:0],
                    CEIL_SPEED_MAX);
                OFS_JOG_CTRL: begin
                    jogOn_d = wd_q[0];
                    mode_d = wd_q[12:8];
                end
                OFS_ANALOG_THR: thr_d = wd_q[15:0];
                OFS_ANALOG_CMD: acmd_d = wd_q[15:0];
                OFS_MOVE_CTRL: mctl_d = wd_q[2:0];
                default: ;
            endcase
        end
        if (tmStart) begin
            case (wd_q[1:0])
                2'h0: reply_d = {17'h0, dly_q};
                2'h1: reply_d = {16'h0, chg_q};
                2'h2: reply_d = {16'h0, mov_q};
                default: reply_d = {16'h0, ceil_q};
            endcase
        end
    end

    // derived motion outputs
    always_comb begin
        clamp_d = (acmd_q > ceil_q) ? ceil_q : acmd_q;
        if (!analogMode) begin
            clamp_d = 16'h0;
        end
        // bit0 run, bit1 jog move, bit2 past change point
        prof_d = 16'h0;
        if (mctl_q[0] && !mctl_q[1]) begin
            prof_d = mctl_q[2] ? chg_q : mov_q;
        end
        jogAct_d = wif.pending && jogOn_q && mode_q == CTRL_MODE_JOG;
        stall_d = wif.pending || waitStart;
        go_d = tmFire;
    end

    // axi read channel
    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            case (s_axi_araddr)
                OFS_REPLY_DELAY: rd_d = {17'h0, dly_q};
                OFS_CHANGE_SPEED: rd_d = {16'h0, chg_q};
                OFS_MOVE_SPEED: rd_d = {16'h0, mov_q};
                OFS_SPEED_CEIL: rd_d = {16'h0, ceil_q};
                OFS_JOG_CTRL: rd_d = {19'h0, mode_q, 7'h0, jogOn_q};
                OFS_ANALOG_THR: rd_d = {16'h0, thr_q};
                OFS_STATUS: rd_d = {24'h0, s2_q, tmBusy, jogAct_q, stall_q, 2'h0};
                OFS_ANALOG_CMD: rd_d = {16'h0, acmd_q};
                OFS_CLAMPED: rd_d = {16'h0, clamp_q};
                OFS_REPLY_REQ: rd_d = {reply_q[23:0], CHAR_CR};
                OFS_MOVE_CTRL: rd_d = {29'h0, mctl_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dly_q <= REPLY_DELAY_RST;
            chg_q <= CHANGE_SPEED_RST;
            mov_q <= MOVE_SPEED_RST;
            ceil_q <= CEIL_SPEED_RST;
            thr_q <= 16'h0;
            acmd_q <= 16'h0;
            clamp_q <= 16'h0;
            prof_q <= 16'h0;
            jogOn_q <= 1'b0;
            mode_q <= 5'h0;
            stall_q <= 1'b0;
            jogAct_q <= 1'b0;
            go_q <= 1'b0;
            mctl_q <= 3'h0;
            reply_q <= 32'h0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awa_q <= 8'h0;
            wd_q <= 32'h0;
            bv_q <= 1'b0;
            br_q <= RESP_OKAY;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= RESP_OKAY;
        end else begin
            dly_q <= dly_d;
            chg_q <= chg_d;
            mov_q <= mov_d;
            ceil_q <= ceil_d;
            thr_q <= thr_d;
            acmd_q <= acmd_d;
            clamp_q <= clamp_d;
            prof_q <= prof_d;
            jogOn_q <= jogOn_d;
            mode_q <= mode_d;
            stall_q <= stall_d;
            jogAct_q <= jogAct_d;
            go_q <= go_d;
            mctl_q <= mctl_d;
            reply_q <= reply_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    assign wif.start = waitStart;
    assign wif.sel = wd_q[9:8];
    assign wif.cond = wd_q[7:0];
    assign wif.useAnalog = wd_q[10];

    mpw_input_wait u_wait (
        .clk(clk),
        .rstn(rstn),
        .pulseLvl(s2_q[0]),
        .headingLvl(s2_q[1]),
        .gateLvl(s2_q[2]),
        .analogHigh(a2_q > thr_q),
        .w(wif)
    );

    mpw_delay_timer #(.MS_CYCLES(MS_CYCLES)) u_tmr (
        .clk(clk),
        .rstn(rstn),
        .start(tmStart),
        .delayMs(dly_q),
        .busy(tmBusy),
        .fire(tmFire)
    );

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign bufferStall = stall_q;
    assign jogInputsActive = jogAct_q;
    assign profileSpeed = prof_q;
    assign clampedSpeed = clamp_q;
    assign replyGo = go_q;

    a_clamp_ceiling: assert property (@(posedge clk)
        disable iff (!rstn) clamp_q <= ceil_q || $changed(ceil_q))
        else $error("clamped speed above ceiling");
    a_move_range: assert property (@(posedge clk)
        disable iff (!rstn) mov_q >= SPEED_MIN && mov_q <= MOVE_SPEED_MAX)
        else $error("move speed out of range");
    a_change_range: assert property (@(posedge clk)
        disable iff (!rstn) chg_q <= CEIL_SPEED_MAX)
        else $error("change speed out of range");
    a_delay_zero: assert property (@(posedge clk)
        disable iff (!rstn) tmStart && dly_q == 15'h0 |-> ##2 tmFire)
        else $error("zero delay reply not released");
    a_jog_off: assert property (@(posedge clk)
        disable iff (!rstn) !jogOn_q |=> !jogInputsActive)
        else $error("jog inputs active while jog off");
    a_jog_mode: assert property (@(posedge clk)
        disable iff (!rstn) jogInputsActive |-> $past(wif.pending)
        && $past(mode_q) == CTRL_MODE_JOG)
        else $error("jog inputs active outside wait or mode");
    a_stall_wait: assert property (@(posedge clk)
        disable iff (!rstn) waitStart |=> bufferStall)
        else $error("buffer not stalled on wait");
    a_jog_speed: assert property (@(posedge clk)
        disable iff (!rstn) mctl_q[1] |=> profileSpeed == 16'h0)
        else $error("jog move used move speed");
    a_change_phase: assert property (@(posedge clk)
        disable iff (!rstn) mctl_q == 3'h5 |=> profileSpeed == $past(chg_q))
        else $error("change phase speed wrong");
endmodule : mpw_top
`default_nettype wire

// ---- logic/mpw_pkg.sv ----
// Purpose: shared constants and the speed clamp function for the motion parameter block
// Assumes: 50 MHz clock, AXI4-Lite register access with 32-bit data
// Notes: speeds are held in units of 0.0042 rev/sec
package mpw_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam logic [7:0] OFS_REPLY_DELAY = 8'h00;
    localparam logic [7:0] OFS_CHANGE_SPEED = 8'h04;
    localparam logic [7:0] OFS_MOVE_SPEED = 8'h08;
    localparam logic [7:0] OFS_SPEED_CEIL = 8'h0c;
    localparam logic [7:0] OFS_INPUT_WAIT = 8'h10;
    localparam logic [7:0] OFS_JOG_CTRL = 8'h14;
    localparam logic [7:0] OFS_ANALOG_THR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_ANALOG_CMD = 8'h20;
    localparam logic [7:0] OFS_CLAMPED = 8'h24;
    localparam logic [7:0] OFS_REPLY_REQ = 8'h28;
    localparam logic [7:0] OFS_MOVE_CTRL = 8'h2c;
    localparam logic [14:0] REPLY_DELAY_MAX = 15'h7fff;
    localparam logic [14:0] REPLY_DELAY_RST = 15'h0000;
    localparam logic [15:0] SPEED_MIN = 16'h0001;
    localparam logic [15:0] MOVE_SPEED_MAX = 16'h4a66;
    localparam logic [15:0] CEIL_SPEED_MAX = 16'h7c01;
    localparam logic [15:0] CHANGE_SPEED_RST = 16'h04a6;
    localparam logic [15:0] MOVE_SPEED_RST = 16'h00ee;
    localparam logic [15:0] CEIL_SPEED_RST = 16'h7c01;
    localparam logic [1:0] SEL_PULSE = 2'h1;
    localparam logic [1:0] SEL_HEADING = 2'h2;
    localparam logic [1:0] SEL_GATE = 2'h3;
    localparam logic [7:0] COND_L = 8'h4c;
    localparam logic [7:0] COND_H = 8'h48;
    localparam logic [7:0] COND_F = 8'h46;
    localparam logic [7:0] COND_R = 8'h52;
    localparam logic [4:0] CTRL_MODE_JOG = 5'h15;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    function automatic logic [15:0] mpw_clamp(input logic [15:0] v,
                                              input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < SPEED_MIN) begin
            r = SPEED_MIN;
        end
        if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : mpw_clamp
endpackage : mpw_pkg

// ---- logic/mpw_wait_if.sv ----
// Purpose: carries an input wait request and its completion
// Assumes: single clock
// Notes: start is a pulse, done is a pulse
`timescale 1ns/1ps
`default_nettype none
interface mpw_wait_if;
    logic start;
    logic [1:0] sel;
    logic [7:0] cond;
    logic useAnalog;
    logic pending;
    logic done;
    modport ctl(output start, output sel, output cond, output useAnalog,
                input pending, input done);
    modport unit(input start, input sel, input cond, input useAnalog,
                 output pending, output done);
endinterface : mpw_wait_if
`default_nettype wire

// ---- logic/mpw_input_wait.sv ----
// Purpose: holds the command buffer until a chosen input condition is met
// Assumes: inputs already synchronised; 1 = no current
// Notes: edges are detected from the level one cycle earlier; the first pending cycle never counts as an edge
`timescale 1ns/1ps
`default_nettype none
module mpw_input_wait
    import mpw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // synchronised input levels
    input wire logic pulseLvl,
    input wire logic headingLvl,
    input wire logic gateLvl,
    input wire logic analogHigh,
    // request side
    mpw_wait_if.unit w
);
    logic pend_q, pend_d;
    logic prev_q, prev_d;
    logic [1:0] sel_q, sel_d;
    logic [7:0] cond_q, cond_d;
    logic ana_q, ana_d;
    logic done_q, done_d;
    logic lvl;

    always_comb begin
        lvl = gateLvl;
        if (ana_q) begin
            lvl = analogHigh;
        end else begin
            case (sel_q)
                SEL_PULSE: lvl = pulseLvl;
                SEL_HEADING: lvl = headingLvl;
                default: lvl = gateLvl;
            endcase
        end
    end

    always_comb begin
        pend_d = pend_q;
        prev_d = lvl;
        sel_d = sel_q;
        cond_d = cond_q;
        ana_d = ana_q;
        done_d = 1'b0;
        if (w.start && !pend_q) begin
            pend_d = 1'b1;
            prev_d = (w.cond == COND_R); // no false edge on the first cycle
            sel_d = w.sel;
            cond_d = w.cond;
            ana_d = w.useAnalog;
        end else if (pend_q) begin
            case (cond_q)
                COND_L: done_d = !lvl;
                COND_H: done_d = lvl;
                COND_F: done_d = prev_q && !lvl;
                COND_R: done_d = !prev_q && lvl;
                default: done_d = 1'b1;
            endcase
            if (done_d) begin
                pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
            prev_q <= 1'b1;
            sel_q <= SEL_GATE;
            cond_q <= COND_L;
            ana_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            prev_q <= prev_d;
            sel_q <= sel_d;
            cond_q <= cond_d;
            ana_q <= ana_d;
            done_q <= done_d;
        end
    end

    assign w.pending = pend_q;
    assign w.done = done_q;

    a_done_clears: assert property (@(posedge clk)
        disable iff (!rstn) done_q |-> !pend_q)
        else $error("wait still pending after done");
endmodule : mpw_input_wait
`default_nettype wire

// ---- logic/mpw_delay_timer.sv ----
// Purpose: millisecond delay before a reply is released
// Assumes: CYC_PER_MS cycles per millisecond
// Notes: a zero delay raises fire two cycles after start
`timescale 1ns/1ps
`default_nettype none
module mpw_delay_timer
    import mpw_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic start,
    input wire logic [14:0] delayMs,
    output logic busy,
    output logic fire
);
    logic [14:0] ms_q, ms_d;
    logic [31:0] cyc_q, cyc_d;
    logic busy_q, busy_d;
    logic fire_q, fire_d;

    always_comb begin
        ms_d = ms_q;
        cyc_d = cyc_q;
        busy_d = busy_q;
        fire_d = 1'b0;
        if (start && !busy_q) begin
            busy_d = 1'b1;
            ms_d = delayMs;
            cyc_d = 32'h0;
        end else if (busy_q) begin
            if (ms_q == 15'h0) begin
                busy_d = 1'b0;
                fire_d = 1'b1;
            end else if (cyc_q == 32'(MS_CYCLES - 1)) begin
                cyc_d = 32'h0;
                ms_d = ms_q - 15'h1;
            end else begin
                cyc_d = cyc_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_q <= 15'h0;
            cyc_q <= 32'h0;
            busy_q <= 1'b0;
            fire_q <= 1'b0;
        end else begin
            ms_q <= ms_d;
            cyc_q <= cyc_d;
            busy_q <= busy_d;
            fire_q <= fire_d;
        end
    end

    assign busy = busy_q;
    assign fire = fire_q;
endmodule : mpw_delay_timer
`default_nettype wire

// ---- tb/mpw_field_model.sv ----
// Purpose: far-side model of the opto inputs and the analog source
// Assumes: bench commands when current flows through each input
// Notes: no current or open terminal reads as high
`timescale 1ns/1ps
`default_nettype none
module mpw_field_model (
    // commands from the bench
    input wire logic [2:0] currentOn,
    input wire logic [15:0] analogLevel,
    // drive pins
    output logic pulsePin,
    output logic headingPin,
    output logic gatePin,
    output logic [15:0] analogPin
);
    // input 1 pulse, 2 heading, 3 gate; current flowing reads low
    assign pulsePin = ~currentOn[0];
    assign headingPin = ~currentOn[1];
    assign gatePin = ~currentOn[2];
    assign analogPin = analogLevel;
endmodule : mpw_field_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: register level tests of the motion parameter block
// Assumes: AXI4-Lite master tasks, MS_CYCLES shortened to 4
// Notes: pin levels come from the field model
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mpw_pkg::*;
;
    localparam int MSC = 4;
    logic clk, rstn, analogMode, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, bufferStall;
    logic jogInputsActive, replyGo, pulsePin, headingPin, gatePin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] analogPin, analogLevel, profileSpeed, clampedSpeed;
    logic [2:0] currentOn;
    logic [7:0] conds [4];
    logic [3:0] startHi;
    logic [31:0] jogCfg [3];
    int mismatches = 0;
    int num_checks = 0;

    mpw_top #(.MS_CYCLES(MSC)) u_dut (.clk, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pulsePin, .headingPin, .gatePin, .analogPin, .analogMode,
        .bufferStall, .jogInputsActive, .profileSpeed, .clampedSpeed,
        .replyGo);
    mpw_field_model u_field (.currentOn, .analogLevel, .pulsePin,
        .headingPin, .gatePin, .analogPin);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task tmo(input string what);
        mismatches++;
        $display("MISMATCH %s expected answer seen timeout", what);
        final_report();
    endtask : tmo

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) tmo("bvalid");
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) tmo("rvalid");
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask : rdc

    task waitStall;
        int n;
        for (n = 0; n < 20 && bufferStall !== 1'b0; n++) @(posedge clk);
        if (n == 20) tmo("stall release");
        num_checks++;
    endtask : waitStall

    task replyWait(input int ms);
        int n;
        for (n = 0; n < 200 && replyGo !== 1'b1; n++) @(posedge clk);
        if (n == 200) tmo("replyGo");
        chk("reply delay", 1, (n >= ms * MSC - 3) && (n <= ms * MSC + 5));
    endtask : replyWait

    initial begin
        rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, analogMode} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        currentOn = 3'h0;
        analogLevel = 16'h0000;
        conds = '{COND_L, COND_H, COND_F, COND_R};
        startHi = 4'b0101;
        jogCfg = '{32'h00001501, 32'h00001401, 32'h00001500};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rdc(OFS_REPLY_DELAY, 32'h0, RESP_OKAY);
        rdc(OFS_CHANGE_SPEED, 32'h04a6, RESP_OKAY);
        rdc(OFS_MOVE_SPEED, {16'h0, MOVE_SPEED_RST}, RESP_OKAY);
        rdc(OFS_SPEED_CEIL, {16'h0, CEIL_SPEED_RST}, RESP_OKAY);
        wr(OFS_MOVE_SPEED, 32'h0, RESP_OKAY);
        rdc(OFS_MOVE_SPEED, {16'h0, SPEED_MIN}, RESP_OKAY);
        wr(OFS_MOVE_SPEED, 32'hffff, RESP_OKAY);
        rdc(OFS_MOVE_SPEED, {16'h0, MOVE_SPEED_MAX}, RESP_OKAY);
        wr(OFS_CHANGE_SPEED, 32'hffff, RESP_OKAY);
        rdc(OFS_CHANGE_SPEED, {16'h0, CEIL_SPEED_MAX}, RESP_OKAY);
        wr(OFS_REPLY_DELAY, 32'hffff, RESP_OKAY);
        rdc(OFS_REPLY_DELAY, {17'h0, REPLY_DELAY_MAX}, RESP_OKAY);
        wr(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h02, 32'h0, RESP_SLVERR);
        wr(OFS_STATUS, 32'h0, RESP_SLVERR);
        rdc(8'h30, 32'h0, RESP_SLVERR);
        wr(OFS_REPLY_DELAY, 32'h0, RESP_OKAY);
        wr(OFS_MOVE_SPEED, 32'h0200, RESP_OKAY);
        wr(OFS_REPLY_REQ, 32'h2, RESP_OKAY);
        replyWait(0);
        rdc(OFS_REPLY_REQ, {24'h000200, 8'h0d}, RESP_OKAY);
        wr(OFS_REPLY_DELAY, 32'h2, RESP_OKAY);
        wr(OFS_REPLY_REQ, 32'h0, RESP_OKAY);
        replyWait(2);
        rdc(OFS_REPLY_REQ, {24'h000002, 8'h0d}, RESP_OKAY);
        wr(OFS_CHANGE_SPEED, 32'h0300, RESP_OKAY);
        wr(OFS_MOVE_CTRL, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("profileSpeed", 32'h0200, {16'h0, profileSpeed});
        wr(OFS_MOVE_CTRL, 32'h5, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("profileSpeed", 32'h0300, {16'h0, profileSpeed});
        wr(OFS_MOVE_CTRL, 32'h3, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("profileSpeed", 32'h0, {16'h0, profileSpeed});
        wr(OFS_SPEED_CEIL, 32'h1000, RESP_OKAY);
        wr(OFS_ANALOG_CMD, 32'h9000, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("clampedSpeed", 32'h0, {16'h0, clampedSpeed});
        analogMode <= 1'b1;
        repeat (4) @(posedge clk);
        chk("clampedSpeed", 32'h1000, {16'h0, clampedSpeed});
        wr(OFS_ANALOG_CMD, 32'h0800, RESP_OKAY);
        repeat (4) @(posedge clk);
        chk("clampedSpeed", 32'h0800, {16'h0, clampedSpeed});
        for (int s = 1; s <= 3; s++) begin
            for (int c = 0; c < 4; c++) begin
                currentOn[s-1] <= ~startHi[c];
                repeat (4) @(posedge clk);
                wr(OFS_INPUT_WAIT, {22'h0, 2'(s), conds[c]}, RESP_OKAY);
                repeat (3) @(posedge clk);
                chk("stall", 32'h1, {31'h0, bufferStall});
                currentOn[s-1] <= startHi[c];
                waitStall();
            end
            currentOn[s-1] <= 1'b0;
        end
        for (int j = 0; j < 3; j++) begin
            wr(OFS_JOG_CTRL, jogCfg[j], RESP_OKAY);
            repeat (4) @(posedge clk);
            wr(OFS_INPUT_WAIT, {22'h0, 2'h3, COND_L}, RESP_OKAY);
            if (j == 0) wr(OFS_MOVE_SPEED, 32'h0111, RESP_OKAY);
            repeat (2) @(posedge clk);
            chk("jog", 32'(j == 0), {31'h0, jogInputsActive});
            currentOn[2] <= 1'b1;
            waitStall();
            currentOn[2] <= 1'b0;
        end
        rdc(OFS_MOVE_SPEED, 32'h0200, RESP_OKAY);
        wr(OFS_ANALOG_THR, 32'h1000, RESP_OKAY);
        analogLevel <= 16'h2000;
        repeat (4) @(posedge clk);
        wr(OFS_INPUT_WAIT, {21'h0, 1'b1, 2'h1, COND_L}, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("stall", 32'h1, {31'h0, bufferStall});
        analogLevel <= 16'h0800;
        waitStall();
        wr(OFS_INPUT_WAIT, {21'h0, 1'b1, 2'h1, COND_H}, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("stall", 32'h1, {31'h0, bufferStall});
        analogLevel <= 16'h2000;
        waitStall();
        final_report();
    end
endmodule : testbench
`default_nettype wire
